// [utr_pkg.sv]
// Purpose: Shared constants and carrier types for the user trim register bank
// Assumes: 8-bit registers, each on one aligned 32-bit Wishbone word
// Notes:   Printed offsets are register indices; byte address is four times the index

package utr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] UTR_IDX_Z_OFFSET = 8'h35;
  localparam logic [7:0] UTR_IDX_X_GAIN   = 8'h36;
  localparam logic [7:0] UTR_IDX_Y_GAIN   = 8'h37;
  localparam logic [7:0] UTR_IDX_Z_GAIN   = 8'h38;
  localparam int         UTR_ADDR_W       = 10;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         UTR_OFS_W        = 5;
  localparam int         UTR_GAIN_W       = 6;
  localparam int         UTR_FACT_OFS_W   = 6;
  localparam int         UTR_FACT_GAIN_W  = 7;
  localparam logic [4:0] UTR_OFS_RST      = 5'h00;
  localparam logic [5:0] UTR_GAIN_RST     = 6'h00;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } utr_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } utr_wb_rsp_t;

  typedef struct packed {
    logic signed [5:0] z_ofs;
    logic signed [6:0] x_gain;
    logic signed [6:0] y_gain;
    logic signed [6:0] z_gain;
  } utr_trim_t;

endpackage

// [utr_regs.sv]
// Purpose: User offset and gain trim registers on a classic Wishbone slave
// Assumes: Single clock, synchronous active-high reset, 32-bit data bus
// Notes:   Effective trims combine user and factory values with saturation
//
// Register access over Wishbone was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Z offset trim, five bits, signed
// - X gain trim, six bits, signed
// - Y gain trim, six bits, signed
// - Z gain trim, six bits, signed
// - Registers at 0x35..0x38, reset to zero
// - User and factory trims share one range
// - Upper register bits reserved, read-only zero
module utr_regs
  import utr_pkg::*;
(
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // Wishbone slave
  input  wire utr_pkg::utr_wb_req_t              wb_req_i,
  output utr_pkg::utr_wb_rsp_t                   wb_rsp_o,
  // Factory trims from fuses
  input  wire logic signed [utr_pkg::UTR_FACT_OFS_W-1:0]  fact_z_ofs_i,
  input  wire logic signed [utr_pkg::UTR_FACT_GAIN_W-1:0] fact_x_gain_i,
  input  wire logic signed [utr_pkg::UTR_FACT_GAIN_W-1:0] fact_y_gain_i,
  input  wire logic signed [utr_pkg::UTR_FACT_GAIN_W-1:0] fact_z_gain_i,
  // Combined trims to the signal path
  output utr_pkg::utr_trim_t                     trim_o,
  output logic [3:0]                             trim_clip_o
);

  import utr_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [UTR_OFS_W-1:0]  z_ofs;
    logic [UTR_GAIN_W-1:0] x_gain;
    logic [UTR_GAIN_W-1:0] y_gain;
    logic [UTR_GAIN_W-1:0] z_gain;
    logic                  ack;
    logic                  err;
    logic [7:0]            rdat;
    utr_trim_t             trim;
    logic [3:0]            clip;
  } utr_state_t;

  utr_state_t st_ff;
  utr_state_t nxt_st;

  // Index decode, shared by read and write
  function automatic logic [2:0] utr_decode(input logic [31:0] adr);
    logic [2:0] r;
    r = 3'h4;
    if (adr[31:UTR_ADDR_W] == '0 && adr[1:0] == 2'h0) begin
      unique case (adr[UTR_ADDR_W-1:2])
        UTR_IDX_Z_OFFSET: r = 3'h0;
        UTR_IDX_X_GAIN:   r = 3'h1;
        UTR_IDX_Y_GAIN:   r = 3'h2;
        UTR_IDX_Z_GAIN:   r = 3'h3;
        default:          r = 3'h4;
      endcase
    end
    return r;
  endfunction

  // ****************************************
  // Trim combining
  // ****************************************
  logic signed [UTR_FACT_OFS_W-1:0]  sum_z_ofs;
  logic signed [UTR_FACT_GAIN_W-1:0] sum_x_gain;
  logic signed [UTR_FACT_GAIN_W-1:0] sum_y_gain;
  logic signed [UTR_FACT_GAIN_W-1:0] sum_z_gain;
  logic [3:0]                        clip_now;

  utr_trim_combine #(.USER_W(UTR_OFS_W), .OUT_W(UTR_FACT_OFS_W)) u_z_ofs (
    .user_i (signed'(st_ff.z_ofs)),
    .fact_i (fact_z_ofs_i),
    .sum_o  (sum_z_ofs),
    .clip_o (clip_now[0])
  );
  utr_trim_combine #(.USER_W(UTR_GAIN_W), .OUT_W(UTR_FACT_GAIN_W)) u_x_gain (
    .user_i (signed'(st_ff.x_gain)),
    .fact_i (fact_x_gain_i),
    .sum_o  (sum_x_gain),
    .clip_o (clip_now[1])
  );
  utr_trim_combine #(.USER_W(UTR_GAIN_W), .OUT_W(UTR_FACT_GAIN_W)) u_y_gain (
    .user_i (signed'(st_ff.y_gain)),
    .fact_i (fact_y_gain_i),
    .sum_o  (sum_y_gain),
    .clip_o (clip_now[2])
  );
  utr_trim_combine #(.USER_W(UTR_GAIN_W), .OUT_W(UTR_FACT_GAIN_W)) u_z_gain (
    .user_i (signed'(st_ff.z_gain)),
    .fact_i (fact_z_gain_i),
    .sum_o  (sum_z_gain),
    .clip_o (clip_now[3])
  );

  // ****************************************
  // Next state
  // ****************************************
  logic [2:0] sel_idx;
  logic       req;

  // Bus decode, register writes and read mux
  always_comb begin
    nxt_st  = st_ff;
    sel_idx = utr_decode(wb_req_i.adr);
    req     = wb_req_i.cyc & wb_req_i.stb & ~st_ff.ack & ~st_ff.err;
    nxt_st.ack  = 1'b0;
    nxt_st.err  = 1'b0;
    nxt_st.rdat = 8'h00;
    if (req) begin
      // Unmapped or misaligned access answers with err
      nxt_st.ack = (sel_idx != 3'h4);
      nxt_st.err = (sel_idx == 3'h4);
      if (wb_req_i.we && wb_req_i.sel[0]) begin
        unique case (sel_idx)
          3'h0: nxt_st.z_ofs  = wb_req_i.dat[UTR_OFS_W-1:0];
          3'h1: nxt_st.x_gain = wb_req_i.dat[UTR_GAIN_W-1:0];
          3'h2: nxt_st.y_gain = wb_req_i.dat[UTR_GAIN_W-1:0];
          3'h3: nxt_st.z_gain = wb_req_i.dat[UTR_GAIN_W-1:0];
          default: ;
        endcase
      end
      unique case (sel_idx)
        3'h0: nxt_st.rdat = {3'h0, st_ff.z_ofs};
        3'h1: nxt_st.rdat = {2'h0, st_ff.x_gain};
        3'h2: nxt_st.rdat = {2'h0, st_ff.y_gain};
        3'h3: nxt_st.rdat = {2'h0, st_ff.z_gain};
        default: nxt_st.rdat = 8'h00;
      endcase
    end
    // Trims are registered so the signal path sees a clean value
    nxt_st.trim.z_ofs  = sum_z_ofs;
    nxt_st.trim.x_gain = sum_x_gain;
    nxt_st.trim.y_gain = sum_y_gain;
    nxt_st.trim.z_gain = sum_z_gain;
    nxt_st.clip        = clip_now;
  end

  // ****************************************
  // State register
  // ****************************************
  // zero trims after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff        <= '0;
      st_ff.z_ofs  <= UTR_OFS_RST;
      st_ff.x_gain <= UTR_GAIN_RST;
      st_ff.y_gain <= UTR_GAIN_RST;
      st_ff.z_gain <= UTR_GAIN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign wb_rsp_o.ack = st_ff.ack;
  assign wb_rsp_o.err = st_ff.err;
  assign wb_rsp_o.dat = {24'h000000, st_ff.rdat};
  assign trim_o       = st_ff.trim;
  assign trim_clip_o  = st_ff.clip;

endmodule // utr_regs

`default_nettype wire

// [utr_regs_monitor.sv]
// Purpose: Port assertions for the trim bank
// Assumes: One clock, sync active-high reset
// Notes:   Bound into every utr_regs instance
`timescale 1ns/1ps
`default_nettype none
module utr_regs_monitor
  import utr_pkg::*;
(
  // Watched ports
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire utr_pkg::utr_wb_req_t wb_req_i,
  input wire utr_pkg::utr_wb_rsp_t wb_rsp_o,
  input wire logic signed [6:0]    fact_x_gain_i,
  input wire utr_pkg::utr_trim_t   trim_o
);
  // ************
  // Checks
  // ************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        tk;
  logic [31:0] a;
  // Request taken only while no answer is showing
  assign tk = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack & ~wb_rsp_o.err;
  assign a  = wb_req_i.adr;
  AST_ANSWER: assert property (tk |=> wb_rsp_o.ack ^ wb_rsp_o.err) else $error("no answer");
  AST_PULSE: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack) else $error("ack held");
  AST_CAUSE: assert property (wb_rsp_o.ack |-> $past(tk)) else $error("stray ack");
  AST_UNMAP: assert property (tk && (a[1:0] != 0 || a < 32'hd4 || a > 32'he0) |=> wb_rsp_o.err)
    else $error("no err");
  AST_HIGH: assert property (wb_rsp_o.dat[31:8] == 0) else $error("high bits set");
  AST_OFS: assert property (wb_rsp_o.ack && $past(a) == 32'hd4 |-> wb_rsp_o.dat[7:5] == 0) else $error("ofs");
  AST_GAIN: assert property (wb_rsp_o.ack && $past(a) > 32'hd4 |-> wb_rsp_o.dat[7:6] == 0) else $error("gain");
  AST_XTRIM: assert property (tk && wb_req_i.we && wb_req_i.sel[0] && a == 32'hd8 && fact_x_gain_i == 0
    ##1 $stable(fact_x_gain_i) |=> trim_o.x_gain == {$past(wb_req_i.dat[5], 2), $past(wb_req_i.dat[5:0], 2)})
    else $error("x trim");
  cover property (tk && wb_req_i.we ##1 wb_rsp_o.ack);
  cover property (tk && !wb_req_i.we ##1 wb_rsp_o.ack);
  cover property (wb_rsp_o.err);
endmodule // utr_regs_monitor
bind utr_regs utr_regs_monitor utr_regs_monitor_i (.*);
`default_nettype wire

// [utr_regs_tb_top.sv]
// Purpose: Self-checking bench for the trim bank
// Assumes: Slave answers with ack or err; the master waits for it, bounded
// Notes:   Answers and outputs are sampled on rising edges, before they update
`timescale 1ns/1ps
`default_nettype none
module utr_regs_tb_top;
  import utr_pkg::*;
  logic clk_i, rst_i, e;
  utr_wb_req_t req = '0;
  utr_wb_rsp_t rsp;
  logic signed [5:0] fzo = '0;
  logic signed [6:0] fx = '0, fy = '0, fz = '0;
  utr_trim_t trim;
  logic [3:0] clip;
  logic [31:0] rd;
  int failures, checks;
  utr_regs utr_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .fact_z_ofs_i(fzo),
    .fact_x_gain_i(fx), .fact_y_gain_i(fy), .fact_z_gain_i(fz), .trim_o(trim), .trim_clip_o(clip));
  // ************
  // Tasks
  // ************
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [31:0] s, x);
    checks++;
    if (s !== x) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One classic cycle, entered just after a rising edge; held until ack or err is seen at a rising edge
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, s, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && rsp.err !== 1'b1 && n < 20);
    if (rsp.ack !== 1'b1 && rsp.err !== 1'b1) begin
      failures++;
      give_verdict();
    end else begin
      rd = rsp.dat;
      e = rsp.err;
      req <= '0;
      @(posedge clk_i);
    end
  endtask
  task automatic t_fields;
    logic [31:0] v[2] = '{32'hff, 32'haa};
    for (int r = 0; r < 4; r++) begin
      bus(0, 32'hd4 + 4 * r, 0, 4'h1);
      chk("reset", rd, 0);
      foreach (v[i]) begin
        bus(1, 32'hd4 + 4 * r, v[i], 4'h1);
        bus(0, 32'hd4 + 4 * r, 0, 4'h1);
        chk("field", rd, v[i] & (r == 0 ? 32'h1f : 32'h3f));
      end
    end
  endtask
  task automatic t_refuse;
    logic [31:0] ad[3] = '{32'he4, 32'hd5, 32'h4d4};
    bus(1, 32'hd8, 32'h15, 4'h0);
    bus(0, 32'hd8, 0, 4'h1);
    chk("sel", rd, 32'h2a);
    foreach (ad[i]) begin
      bus(1, ad[i], 32'h3, 4'h1);
      chk("err", e, 1);
    end
    bus(0, 32'hd4, 0, 4'h1);
    chk("kept", rd, 32'h0a);
  endtask
  task automatic t_share;
    fx <= 7'sd60;
    fz <= -7'sd60;
    fzo <= 6'sd20;
    bus(1, 32'hd8, 32'h1f, 4'h1);
    bus(1, 32'hd4, 32'h10, 4'h1);
    @(posedge clk_i);
    chk("xsat", {trim.x_gain}, 32'h3f);
    chk("zofs", {trim.z_ofs}, 32'h04);
    chk("ygain", {trim.y_gain}, 32'h6a);
    chk("zsat", {trim.z_gain}, 32'h40);
    chk("clip", {clip}, 32'ha);
    fx <= -7'sd10;
    bus(1, 32'hd8, 32'h20, 4'h1);
    @(posedge clk_i);
    chk("xneg", {trim.x_gain}, 32'h56);
  endtask
  // ************
  // Main sequence
  // ************
  initial begin
    rst_i = 1;
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_fields();
    t_refuse();
    t_share();
    give_verdict();
  end
endmodule // utr_regs_tb_top
`default_nettype wire

// [utr_trim_combine.sv]
// Purpose: Adds a user trim to the factory trim inside one shared range
// Assumes: Both operands are two's complement
// Notes:   Result saturates, so a large factory trim leaves less user range

`timescale 1ns/1ps
`default_nettype none

module utr_trim_combine #(
  parameter int USER_W = 5,
  parameter int OUT_W  = 6
) (
  // Operands
  input  wire logic signed [USER_W-1:0] user_i,
  input  wire logic signed [OUT_W-1:0]  fact_i,
  // Result
  output logic signed [OUT_W-1:0]       sum_o,
  output logic                          clip_o
);

  localparam logic signed [OUT_W:0] MAX_V = (OUT_W+1)'((1 << (OUT_W-1)) - 1);
  localparam logic signed [OUT_W:0] MIN_V = -MAX_V - (OUT_W+1)'(1);

  logic signed [OUT_W:0] wide;

  // Shared headroom: sum, then clamp at the range ends
  always_comb begin
    wide   = (OUT_W+1)'(user_i) + (OUT_W+1)'(fact_i);
    clip_o = 1'b0;
    sum_o  = wide[OUT_W-1:0];
    if (wide > MAX_V) begin
      sum_o  = MAX_V[OUT_W-1:0];
      clip_o = 1'b1;
    end else if (wide < MIN_V) begin
      sum_o  = MIN_V[OUT_W-1:0];
      clip_o = 1'b1;
    end
  end

endmodule // utr_trim_combine

`default_nettype wire
